// >>> inc/fcs_defs.svh
// Constants for the flash command sequencer: offsets, fields, codes and timing
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH

// Bus geometry
`define FCS_ADR_W 18
`define FCS_ARRAY_BIT 17
`define FCS_FADDR_W 16

// Register byte offsets in the control region
`define FCS_OFS_DIV 8'h00
`define FCS_OFS_STAT 8'h04
`define FCS_OFS_CMD 8'h08
`define FCS_OFS_PROT 8'h0c

// Divider register fields
`define FCS_DIV_SET_BIT 7
`define FCS_DIV_PRE_BIT 6
`define FCS_DIV_MSB 5

// Status register fields
`define FCS_ST_CBEF 7
`define FCS_ST_CCF 6
`define FCS_ST_PVIOL 5
`define FCS_ST_ACCERR 4

// Protection register fields, page and row address bit positions
`define FCS_PROT_DIS_BIT 0
`define FCS_PROT_MSB 7
`define FCS_PROT_LSB 1
`define FCS_PAGE_LSB 9
`define FCS_ROW_LSB 6

// Command codes
`define FCS_CMD_BLANK 8'h05
`define FCS_CMD_BYTE 8'h20
`define FCS_CMD_BURST 8'h25
`define FCS_CMD_PAGE 8'h40
`define FCS_CMD_MASS 8'h41

// Durations in divided flash clock periods, counter width, prescaler last count
`define FCS_CNT_W 15
`define FCS_BLANK_CYC 15'h0001
`define FCS_BYTE_CYC 15'h0009
`define FCS_BURST_CYC 15'h0004
`define FCS_PAGE_CYC 4000
`define FCS_MASS_CYC 20000
`define FCS_PRE_LAST 3'h7

`endif

// >>> inc/fcs_pkg.sv
// Types shared by the flash command sequencer modules
package fcs_pkg;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_ADDR_DONE,
		SEQ_CMD_DONE
	} fcs_seq_e;

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic div_set;
		logic prdiv8;
		logic [5:0] div;
		logic acc_err;
		logic prot_viol;
		fcs_seq_e seq;
		logic [15:0] cap_addr;
		logic [7:0] cap_data;
		logic [7:0] cap_cmd;
		logic pend;
		logic [15:0] pend_addr;
		logic [7:0] pend_data;
		logic [7:0] pend_cmd;
		logic run;
		logic [15:0] ex_addr;
		logic [7:0] ex_data;
		logic [7:0] ex_cmd;
		logic [14:0] cnt;
		logic pump;
		logic ccf;
		logic done;
		logic [7:0] prot;
	} fcs_state_s;

	typedef struct packed {
		logic [2:0] pre;
		logic [5:0] cnt;
		logic tick;
	} fcs_div_state_s;

endpackage

// >>> rtl/fcs_clk_div.sv
// Divided flash clock generator: one tick per flash clock period
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defs.svh"

module fcs_clk_div
	import fcs_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Divider setting
	input wire logic run_i,
	input wire logic prdiv8_i,
	input wire logic [5:0] div_i,
	// Flash clock tick
	output logic tick_o
);
	import fcs_pkg::*;

	fcs_div_state_s st;
	fcs_div_state_s next_st;
	logic pre_done;

	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		pre_done = !prdiv8_i || (st.pre == `FCS_PRE_LAST);
		if (rst_i || !run_i) begin
			next_st = '0;
		end else begin
			if (prdiv8_i) begin
				next_st.pre = pre_done ? 3'h0 : st.pre + 3'h1;
			end
			if (pre_done) begin
				if (st.cnt == div_i) begin
					next_st.cnt = 6'h00;
					next_st.tick = 1'b1;
				end else begin
					next_st.cnt = st.cnt + 6'h01;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	assign tick_o = st.tick;

endmodule
`default_nettype wire

// >>> rtl/fcs_sequencer.sv
// Flash command sequencer with classic Wishbone register slave
// What this block does
// - No command accepted before divider is set.
// - Divider accepts one write after reset.
// - Divider write ignored while access error set.
// - Pulses timed in divided flash clock periods.
// - Durations 9, burst 4, 4000, 20000 periods.
// - Array write captures address and data operands.
// - Page erase any page address; others ignore.
// - Command codes 05, 20, 25, 40, 41.
// - Writing one to buffer-empty launches command.
// - Writing zero there aborts, sets access error.
// - Complete flag reports command and queue finished.
// - Pump stays on for queued same-row burst not at row offset 0.
// - Row is 64 bytes; new row standard time.
// - No queued burst: pump off at completion.
// - Access error cleared by one; blocks commands.
// - Error on early, busy or repeated array write.
// - Error on repeated or out-of-order register writes; command write before array write ignored.
// - Error on undefined command code.
// - Stop mode aborts running command with error.
// - Secured debug only blank check, mass erase.
// - Protected range blocks program, erase, mass erase.
// - Protection loads at reset; debug-only writes.
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defs.svh"

module fcs_sequencer
	import fcs_pkg::*;
#(
	parameter int unsigned PAGE_ERASE_CYCLES = `FCS_PAGE_CYC,
	parameter int unsigned MASS_ERASE_CYCLES = `FCS_MASS_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`FCS_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// System qualifiers
	input wire logic debug_access_i,
	input wire logic secure_i,
	input wire logic stop_i,
	input wire logic [7:0] nv_prot_i,
	// Flash array side
	output logic pump_on_o,
	output logic op_active_o,
	output logic [7:0] op_cmd_o,
	output logic [15:0] op_addr_o,
	output logic [7:0] op_data_o,
	output logic op_done_o
);
	import fcs_pkg::*;

	fcs_state_s st;
	fcs_state_s next_st;
	logic tick;
	logic req;
	logic wr_do;
	logic in_ctrl;
	logic is_array;
	logic is_div;
	logic is_stat;
	logic is_cmd;
	logic is_prot;
	logic blocked;
	logic [15:0] waddr;
	logic [7:0] wbyte;
	logic [31:0] rd_val;
	logic chain;

	function automatic logic [14:0] full_time(input logic [7:0] cmd);
		logic [14:0] t;
		t = `FCS_BLANK_CYC;
		unique case (cmd)
			`FCS_CMD_BYTE: t = `FCS_BYTE_CYC;
			`FCS_CMD_BURST: t = `FCS_BYTE_CYC;
			`FCS_CMD_PAGE: t = 15'(PAGE_ERASE_CYCLES);
			`FCS_CMD_MASS: t = 15'(MASS_ERASE_CYCLES);
			default: t = `FCS_BLANK_CYC;
		endcase
		return t;
	endfunction

	function automatic logic valid_code(input logic [7:0] cmd);
		return (cmd == `FCS_CMD_BLANK) || (cmd == `FCS_CMD_BYTE) || (cmd == `FCS_CMD_BURST) ||
			(cmd == `FCS_CMD_PAGE) || (cmd == `FCS_CMD_MASS);
	endfunction

	// Protected range is the top of the array from the size field up
	function automatic logic prot_hit(input logic [7:0] prot, input logic [7:0] cmd, input logic [15:0] addr);
		logic hit;
		hit = 1'b0;
		if (!prot[`FCS_PROT_DIS_BIT]) begin
			if (cmd == `FCS_CMD_MASS) begin
				hit = 1'b1;
			end else if (cmd != `FCS_CMD_BLANK) begin
				hit = (addr[15:`FCS_PAGE_LSB] >= prot[`FCS_PROT_MSB:`FCS_PROT_LSB]);
			end
		end
		return hit;
	endfunction

	fcs_clk_div u_clk_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.run_i(st.div_set),
		.prdiv8_i(st.prdiv8),
		.div_i(st.div),
		.tick_o(tick)
	);

	// Bus decode
	always_comb begin
		req = wb_cyc_i && wb_stb_i;
		wr_do = req && st.ack && wb_we_i && wb_sel_i[0];
		is_array = wb_adr_i[`FCS_ARRAY_BIT];
		in_ctrl = !is_array && (wb_adr_i[`FCS_ADR_W-2:8] == '0);
		is_div = in_ctrl && (wb_adr_i[7:0] == `FCS_OFS_DIV);
		is_stat = in_ctrl && (wb_adr_i[7:0] == `FCS_OFS_STAT);
		is_cmd = in_ctrl && (wb_adr_i[7:0] == `FCS_OFS_CMD);
		is_prot = in_ctrl && (wb_adr_i[7:0] == `FCS_OFS_PROT);
		waddr = wb_adr_i[`FCS_FADDR_W-1:0];
		wbyte = wb_dat_i[7:0];
		blocked = st.acc_err || st.prot_viol;
		rd_val = 32'h0000_0000;
		if (is_div) begin
			rd_val[7:0] = {st.div_set, st.prdiv8, st.div};
		end else if (is_stat) begin
			rd_val[`FCS_ST_CBEF] = !st.pend;
			rd_val[`FCS_ST_CCF] = st.ccf;
			rd_val[`FCS_ST_PVIOL] = st.prot_viol;
			rd_val[`FCS_ST_ACCERR] = st.acc_err;
		end else if (is_cmd) begin
			rd_val[7:0] = st.cap_cmd;
		end else if (is_prot) begin
			rd_val[7:0] = st.prot;
		end
	end

	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		chain = 1'b0;

		// Registered ack, write acts on the edge the master sees ack
		if (req && !st.ack) begin
			next_st.ack = 1'b1;
			next_st.rdata = rd_val;
		end else begin
			next_st.ack = 1'b0;
		end

		// Executor: pick up a queued command when idle
		if (!st.run && st.pend) begin
			next_st.run = 1'b1;
			next_st.ex_addr = st.pend_addr;
			next_st.ex_data = st.pend_data;
			next_st.ex_cmd = st.pend_cmd;
			next_st.cnt = full_time(st.pend_cmd);
			next_st.pump = (st.pend_cmd != `FCS_CMD_BLANK);
			next_st.pend = 1'b0;
		end else if (st.run && tick) begin
			if (st.cnt == 15'h0001) begin
				next_st.done = 1'b1;
				chain = st.pend && (st.ex_cmd == `FCS_CMD_BURST) && (st.pend_cmd == `FCS_CMD_BURST) &&
					(st.pend_addr[15:`FCS_ROW_LSB] == st.ex_addr[15:`FCS_ROW_LSB]) &&
					(st.pend_addr[`FCS_ROW_LSB-1:0] != '0);
				if (chain) begin
					next_st.ex_addr = st.pend_addr;
					next_st.ex_data = st.pend_data;
					next_st.ex_cmd = st.pend_cmd;
					next_st.cnt = `FCS_BURST_CYC;
					next_st.pend = 1'b0;
				end else begin
					next_st.run = 1'b0;
					next_st.pump = 1'b0;
				end
			end else begin
				next_st.cnt = st.cnt - 15'h0001;
			end
		end

		// Register writes and the command protocol
		if (wr_do) begin
			if (is_array) begin
				if (!blocked) begin
					if (!st.div_set || st.pend || (st.seq != SEQ_IDLE)) begin
						next_st.acc_err = 1'b1;
						next_st.seq = SEQ_IDLE;
					end else begin
						next_st.cap_addr = waddr;
						next_st.cap_data = wbyte;
						next_st.seq = SEQ_ADDR_DONE;
					end
				end
			end else if (is_cmd) begin
				if (!blocked) begin
					unique case (st.seq)
						SEQ_IDLE: begin
							next_st.cap_cmd = st.cap_cmd;
						end
						SEQ_ADDR_DONE: begin
							if (!valid_code(wbyte)) begin
								next_st.acc_err = 1'b1;
								next_st.seq = SEQ_IDLE;
							end else if (debug_access_i && secure_i && (wbyte != `FCS_CMD_BLANK) &&
								(wbyte != `FCS_CMD_MASS)) begin
								next_st.acc_err = 1'b1;
								next_st.seq = SEQ_IDLE;
							end else begin
								next_st.cap_cmd = wbyte;
								next_st.seq = SEQ_CMD_DONE;
							end
						end
						SEQ_CMD_DONE: begin
							next_st.acc_err = 1'b1;
							next_st.seq = SEQ_IDLE;
						end
					endcase
				end
			end else if (is_stat) begin
				if (wbyte[`FCS_ST_ACCERR]) begin
					next_st.acc_err = 1'b0;
				end
				if (wbyte[`FCS_ST_PVIOL]) begin
					next_st.prot_viol = 1'b0;
				end
				if (st.seq == SEQ_ADDR_DONE) begin
					next_st.acc_err = 1'b1;
					next_st.seq = SEQ_IDLE;
				end else if (st.seq == SEQ_CMD_DONE) begin
					next_st.seq = SEQ_IDLE;
					if (!wbyte[`FCS_ST_CBEF]) begin
						next_st.acc_err = 1'b1;
					end else if (prot_hit(st.prot, st.cap_cmd, st.cap_addr)) begin
						next_st.prot_viol = 1'b1;
					end else begin
						next_st.pend = 1'b1;
						next_st.pend_addr = st.cap_addr;
						next_st.pend_data = st.cap_data;
						next_st.pend_cmd = st.cap_cmd;
					end
				end
			end else if (is_div) begin
				if (st.seq != SEQ_IDLE) begin
					next_st.acc_err = 1'b1;
					next_st.seq = SEQ_IDLE;
				end else if (!st.div_set && !st.acc_err) begin
					next_st.div_set = 1'b1;
					next_st.prdiv8 = wbyte[`FCS_DIV_PRE_BIT];
					next_st.div = wbyte[`FCS_DIV_MSB:0];
				end
			end else if (is_prot) begin
				if (st.seq != SEQ_IDLE) begin
					next_st.acc_err = 1'b1;
					next_st.seq = SEQ_IDLE;
				end else if (debug_access_i) begin
					next_st.prot = wbyte;
				end
			end
		end

		// Stop mode aborts the running and queued commands
		if (stop_i && st.run) begin
			next_st.run = 1'b0;
			next_st.pump = 1'b0;
			next_st.pend = 1'b0;
			next_st.acc_err = 1'b1;
		end

		next_st.ccf = !next_st.run && !next_st.pend;

		if (rst_i) begin
			next_st = '0;
			next_st.seq = SEQ_IDLE;
			next_st.ccf = 1'b1;
			next_st.prot = nv_prot_i;
		end
	end

	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	assign wb_dat_o = st.rdata;
	assign wb_ack_o = st.ack;
	assign pump_on_o = st.pump;
	assign op_active_o = st.run;
	assign op_cmd_o = st.ex_cmd;
	assign op_addr_o = st.ex_addr;
	assign op_data_o = st.ex_data;
	assign op_done_o = st.done;

endmodule
`default_nettype wire

// >>> tb/fcs_checker.sv
// Concurrent checks on the flash command sequencer ports
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defs.svh"
module fcs_checker
	import fcs_pkg::*;
#(
	parameter int unsigned PAGE_ERASE_CYCLES = 4000,
	parameter int unsigned MASS_ERASE_CYCLES = 20000
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Flash side
	input wire logic stop_i,
	input wire logic pump_on_o,
	input wire logic op_active_o,
	input wire logic [7:0] op_cmd_o,
	input wire logic op_done_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	AST_DAT_HI: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("read data upper bits set");
	AST_DONE_ACT: assert property (op_done_o |-> $past(op_active_o))
		else $error("done without active");
	AST_PUMP_PROG: assert property (op_active_o && op_cmd_o inside {`FCS_CMD_BYTE, `FCS_CMD_BURST} |-> pump_on_o)
		else $error("pump off while programming");
	AST_PUMP_OFF: assert property ($fell(op_active_o) |-> !pump_on_o)
		else $error("pump left on");
	AST_BYTE_MIN: assert property ($rose(op_active_o) && op_cmd_o == `FCS_CMD_BYTE |-> !op_done_o [*8])
		else $error("byte program too short");
	AST_STOP: assert property (op_active_o && stop_i |-> ##[1:2] !op_active_o)
		else $error("stop did not abort");
	AST_RST: assert property ($fell(rst_i) |-> !wb_ack_o && !op_active_o && !pump_on_o && !op_done_o)
		else $error("outputs not idle after reset");
	cover property ($rose(op_active_o));
	cover property (op_done_o && op_active_o && pump_on_o);
	cover property (stop_i && op_active_o);
endmodule
`default_nettype wire

// >>> tb/fcs_flash_model.sv
// Flash array stand-in: counts completions, keeps last data
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Sequencer side
	input wire logic op_done_i,
	input wire logic [7:0] op_data_i,
	// Observation
	output logic [7:0] last_data_o,
	output logic [15:0] n_done_o
);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			n_done_o <= 16'h0;
			last_data_o <= 8'h0;
		end else if (op_done_i) begin
			n_done_o <= n_done_o + 16'h1;
			last_data_o <= op_data_i;
		end
	end
endmodule
`default_nettype wire

// >>> tb/tb_fcs_sequencer.sv
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defs.svh"
module tb_fcs_sequencer;
	import fcs_pkg::*;
	localparam int P = 200;
	localparam logic [17:0] RD = {10'h0, `FCS_OFS_DIV};
	localparam logic [17:0] RS = {10'h0, `FCS_OFS_STAT};
	localparam logic [17:0] RC = {10'h0, `FCS_OFS_CMD};
	localparam logic [17:0] RP = {10'h0, `FCS_OFS_PROT};
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, dbg = 0, sec = 0, stp = 0, pump, act, done, ack;
	logic [17:0] adr = '0;
	logic [31:0] wdat = '0, rdat;
	logic [3:0] sel = '0;
	logic [7:0] nv = 8'h01, ocmd, odata, mdat, d, c;
	logic [15:0] oaddr, a, ndone;
	logic [7:0] codes [5] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
	int n_fail = 0, n_tests = 0, n;
	fcs_sequencer #(.PAGE_ERASE_CYCLES(3), .MASS_ERASE_CYCLES(5)) i_fcs_sequencer (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .debug_access_i(dbg), .secure_i(sec), .stop_i(stp), .nv_prot_i(nv),
		.pump_on_o(pump), .op_active_o(act), .op_cmd_o(ocmd), .op_addr_o(oaddr), .op_data_o(odata), .op_done_o(done));
	fcs_flash_model i_fcs_flash_model (.clk_i(clk_i), .rst_i(rst_i), .op_done_i(done), .op_data_i(odata),
		.last_data_o(mdat), .n_done_o(ndone));
	initial forever #12.5 clk_i = ~clk_i;
	function automatic int ticks(input logic [7:0] k);
		case (k)
			`FCS_CMD_BLANK: return 1;
			`FCS_CMD_PAGE: return 3;
			`FCS_CMD_MASS: return 5;
			default: return 9;
		endcase
	endfunction
	task automatic summarize;
		$display("Checks %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic bad;
		n_fail++;
		$display("MISMATCH t=%0t wait timed out", $time);
		summarize();
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [17:0] ad, input logic [7:0] dv, output logic [7:0] r);
		int k;
		k = 0;
		cyc <= 1;
		stb <= 1;
		we <= w;
		sel <= 4'h1;
		adr <= ad;
		wdat <= {24'h0, dv};
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 20);
		if (k >= 20) bad();
		r = rdat[7:0];
		cyc <= 0;
		stb <= 0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [17:0] ad, input logic [7:0] dv);
		logic [7:0] r;
		bus(1, ad, dv, r);
	endtask
	task automatic rchk(input logic [17:0] ad, input logic [7:0] e);
		logic [7:0] r;
		bus(0, ad, 8'h0, r);
		chk(r, e);
	endtask
	task automatic cmd(input logic [15:0] fa, input logic [7:0] dv, input logic [7:0] k);
		wr({2'b10, fa}, dv);
		wr(RC, k);
		wr(RS, 8'h80);
	endtask
	task automatic wdone(output int m);
		m = 0;
		while (done !== 1'b1 && m < 30000) begin
			@(posedge clk_i);
			m++;
		end
		if (m >= 30000) bad();
	endtask
	task automatic err(input logic [7:0] e);
		rchk(RS, e);
		wr(RS, 8'h30);
	endtask
	task automatic span(input int m, input int t);
		chk(m >= (t - 1) * P && m <= t * P + 4, 1);
	endtask
	initial begin
		void'($urandom(90));
		nv = {7'($urandom), 1'b1};
		repeat (20) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		rchk(RS, 8'hc0);
		rchk(RP, nv);
		a = 16'($urandom);
		wr({2'b10, a}, 8'h5a);
		wr(RD, 8'h58);
		rchk(RD, 8'h00);
		err(8'hd0);
		rchk(RS, 8'hc0);
		wr(RD, 8'h58);
		rchk(RD, 8'hd8);
		wr(RD, 8'($urandom));
		rchk(RD, 8'hd8);
		wr({2'b10, a}, 8'h0);
		wr({2'b10, a}, 8'h0);
		cmd(a, 8'h0, `FCS_CMD_BYTE);
		chk(act, 0);
		err(8'hd0);
		foreach (codes[i]) begin
			a = 16'($urandom);
			d = 8'($urandom);
			cmd(a, d, codes[i]);
			if (codes[i] == `FCS_CMD_MASS) rchk(RS, 8'h80);
			wdone(n);
			// Status read above used three edges of the run
			if (codes[i] == `FCS_CMD_MASS) n += 3;
			chk(ocmd, codes[i]);
			span(n, ticks(codes[i]));
			@(posedge clk_i);
			if (codes[i] == `FCS_CMD_BYTE) chk({oaddr, mdat}, {a, d});
			rchk(RS, 8'hc0);
		end
		chk(ndone, 5);
		for (int j = 0; j < 2; j++) begin
			a = {10'($urandom), j ? 6'h3f : 6'h10};
			cmd(a, 8'h11, `FCS_CMD_BURST);
			cmd(a + 16'h1, 8'h22, `FCS_CMD_BURST);
			wdone(n);
			chk(pump, j == 0);
			@(posedge clk_i);
			wdone(n);
			span(n, j ? 9 : 4);
			chk(oaddr, a + 16'h1);
			repeat (2) @(posedge clk_i);
			chk(pump, 0);
		end
		wr({2'b10, a}, 8'h0);
		wr(RS, 8'h00);
		err(8'hd0);
		wr({2'b10, a}, 8'h0);
		wr(RC, `FCS_CMD_BYTE);
		wr(RC, `FCS_CMD_BYTE);
		err(8'hd0);
		wr({2'b10, a}, 8'h0);
		wr(RC, `FCS_CMD_BYTE);
		wr(RD, 8'h58);
		err(8'hd0);
		do c = 8'($urandom); while (c inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41});
		wr({2'b10, a}, 8'h0);
		wr(RC, c);
		err(8'hd0);
		cmd(a, 8'h0, `FCS_CMD_PAGE);
		repeat (9) @(posedge clk_i);
		stp <= 1;
		repeat (3) @(posedge clk_i);
		chk(act, 0);
		stp <= 0;
		err(8'hd0);
		sec <= 1;
		dbg <= 1;
		wr({2'b10, a}, 8'h0);
		wr(RC, `FCS_CMD_BURST);
		err(8'hd0);
		cmd(a, 8'h0, `FCS_CMD_BLANK);
		wdone(n);
		chk(ocmd, `FCS_CMD_BLANK);
		sec <= 0;
		wr(RP, 8'hf0);
		dbg <= 0;
		wr(RP, 8'h01);
		rchk(RP, 8'hf0);
		cmd(16'hfe00, 8'h0, `FCS_CMD_BYTE);
		chk(act, 0);
		err(8'he0);
		cmd(16'h0000, 8'h0, `FCS_CMD_MASS);
		err(8'he0);
		summarize();
	end
endmodule
bind fcs_sequencer fcs_checker #(.PAGE_ERASE_CYCLES(PAGE_ERASE_CYCLES), .MASS_ERASE_CYCLES(MASS_ERASE_CYCLES))
	i_fcs_checker (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .stop_i, .pump_on_o, .op_active_o,
	.op_cmd_o, .op_done_o);
`default_nettype wire
